// [design/adc_ctl_pkg.sv]
// package: register map, field positions, reset values and timing for the converter control
package adc_ctl_pkg;
    localparam logic [7:0] RESULT_ADDR      = 8'hd0;
    localparam logic [7:0] CONTROL_ADDR     = 8'hd1;
    localparam logic [7:0] CONTROL_RESET    = 8'h40;
    localparam int         IRQ_ENABLE_POS   = 7;
    localparam int         DONE_POS         = 6;
    localparam int         START_POS        = 5;
    localparam int         POWER_POS        = 4;
    localparam int         RES_BITS         = 8;
    localparam int         CODE_COUNT       = 256;
    localparam int         CLK_DIV          = 12;
    localparam int         IRQ_VECTOR       = 4;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } bus_req_type;

    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_SYNC    = 2'b01,
        ST_CONVERT = 2'b10
    } conv_state_type;
endpackage

// [design/sar_step_clock.sv]
// sar step clock: one-cycle tick every DIV cycles of the core clock
`timescale 1ns/10ps
`default_nettype none
module sar_step_clock #(
    parameter int DIV = adc_ctl_pkg::CLK_DIV
) (
    input  wire logic clk,     // core clock
    input  wire logic arst_n,  // async reset, active low
    input  wire logic restart, // realign the divider
    output logic      tick     // one-cycle step pulse
);
    import adc_ctl_pkg::*;

    initial begin
        if (DIV < 2 || DIV > 256) $error("divider must be 2 to 256");
    end

    typedef struct packed {
        logic [7:0] cnt;
        logic       tick;
    } div_state_type;

    div_state_type st_r;
    div_state_type st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        if (restart) begin
            st_nxt.cnt = 8'h00;
        end else if (st_r.cnt == 8'(DIV - 1)) begin
            st_nxt.cnt  = 8'h00;
            st_nxt.tick = 1'b1;
        end else begin
            st_nxt.cnt = st_r.cnt + 8'h01;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tick = st_r.tick;
endmodule
`default_nettype wire

// [design/sar_adc_control.sv]
// converter control: registers, start/abort, wait-sync and successive approximation
// Notes on behaviour
// R1: bit 7 gates end-of-conversion interrupt request
// R2: bit 6 completion flag, software cannot write
// R3: start write clears completion flag
// R4: software trusts result only when flag set
// R5: completion flag doubles as interrupt pending
// R6: writing start bit begins a conversion
// R7: start during conversion restarts it fresh
// R8: start bit always reads zero
// R9: bit 4 powers converter up or down
// R10: low four control bits do nothing
// R11: result register read-only, 8-bit code
// R12: result spans 256 equal codes
// R13: without sync, conversion starts immediately, first step one divider period later
// R14: with sync, start waits for wait state
// R15: core must wait right after start
// R16: converter runs in wait, interrupt wakes
// R17: steps timed by oscillator divided by twelve
// R18: reset aborts, control reads 40h
// R19: interrupt goes to core vector four
// R20: msb first, result and flag together
`timescale 1ns/10ps
`default_nettype none
module sar_adc_control
    import adc_ctl_pkg::*;
#(
    parameter int DIV = CLK_DIV
) (
    input  wire logic       CLOCK,      // core oscillator clock, 10 MHz
    input  wire logic       ARST_N,     // async reset, active low
    input  wire logic [7:0] ADDR,       // register address
    input  wire logic [7:0] WDATA,      // write data
    input  wire logic       WR,         // write strobe
    input  wire logic       RD,         // read strobe
    output logic      [7:0] RDATA,      // read data, cycle after RD
    input  wire logic       SYNC_OPT,   // wait-synchronised start option
    input  wire logic       CORE_WAIT,  // core is in the wait state
    input  wire logic       COMP_HIGH,  // comparator: input at or above trial level
    output logic      [7:0] TRIAL_CODE, // trial code to the ladder
    output logic            POWER_ON,   // analog part powered
    output logic            BUSY,       // conversion running
    output logic            IRQ_REQ,    // interrupt request, vector four
    output logic            WAKE        // wake request to the core
);
    initial begin
        if (DIV != CLK_DIV) $error("step divider must be twelve");
        if (RES_BITS != 8 || CODE_COUNT != 256) $error("8-bit converter only");
    end

    typedef struct packed {
        logic           irq_en;
        logic           done;
        logic           power;
        conv_state_type state;
        logic [7:0]     sar;
        logic [7:0]     trial;
        logic [2:0]     bit_idx;
        logic [7:0]     result;
        logic [7:0]     rdata;
        logic           irq;
        logic           busy;
    } ctl_state_type;

    ctl_state_type st_r;
    ctl_state_type st_nxt;
    bus_req_type   req;
    logic          tick;
    logic          start_wr;
    logic          restart;

    assign req.addr  = ADDR;
    assign req.wdata = WDATA;
    assign req.wr    = WR;
    assign req.rd    = RD;

    assign start_wr = req.wr && req.addr == CONTROL_ADDR && req.wdata[START_POS]; // R6
    // divider realigns on every start so the first step lands a full period later
    assign restart  = start_wr || st_r.state != ST_CONVERT;

    sar_step_clock #(
        .DIV(DIV)
    ) u_step (
        .clk    (CLOCK),
        .arst_n (ARST_N),
        .restart(restart),
        .tick   (tick)                                                            // R17
    );

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_nxt       = st_r;
        st_nxt.rdata = 8'h00;
        if (req.rd) begin
            case (req.addr)
                RESULT_ADDR: begin
                    st_nxt.rdata = st_r.result;                                   // R11 R12
                end
                CONTROL_ADDR: begin
                    // start and low bits read as zero
                    st_nxt.rdata = {st_r.irq_en, st_r.done, 1'b0, st_r.power, 4'h0}; // R8 R10
                end
                default: begin
                    st_nxt.rdata = 8'h00;
                end
            endcase
        end

        // sequencing keeps stepping in the wait state
        case (st_r.state)
            ST_IDLE: begin
                st_nxt.busy = 1'b0;
            end
            ST_SYNC: begin
                if (CORE_WAIT) begin
                    st_nxt.state = ST_CONVERT;                                    // R14
                end
            end
            ST_CONVERT: begin
                if (tick) begin                                                   // R16
                    if (COMP_HIGH) begin
                        st_nxt.sar = st_r.trial;
                    end
                    if (st_r.bit_idx == 3'h0) begin
                        st_nxt.result = COMP_HIGH ? st_r.trial : st_r.sar;        // R20
                        st_nxt.done   = 1'b1;                                     // R20
                        st_nxt.state  = ST_IDLE;
                        st_nxt.busy   = 1'b0;
                    end else begin
                        st_nxt.bit_idx = st_r.bit_idx - 3'h1;
                        st_nxt.trial   = (COMP_HIGH ? st_r.trial : st_r.sar)
                                         | (8'h01 << (st_r.bit_idx - 3'h1));      // R20
                    end
                end
            end
            default: begin
                st_nxt.state = ST_IDLE;
            end
        endcase

        if (req.wr && req.addr == CONTROL_ADDR) begin
            st_nxt.irq_en = req.wdata[IRQ_ENABLE_POS];                            // R1
            st_nxt.power  = req.wdata[POWER_POS];                                 // R9
            // bit 6 of write data is ignored
            if (req.wdata[START_POS]) begin
                st_nxt.done = 1'b0;                                               // R2 R3
            end
        end

        if (!st_nxt.power) begin
            st_nxt.state = ST_IDLE;                                               // R9
            st_nxt.busy  = 1'b0;
        end else if (start_wr) begin
            // abandon any running conversion and seed the msb trial
            st_nxt.sar     = 8'h00;                                               // R7
            st_nxt.trial   = 8'h80;
            st_nxt.bit_idx = 3'h7;
            st_nxt.busy    = 1'b1;
            st_nxt.state   = SYNC_OPT ? ST_SYNC : ST_CONVERT;                     // R13 R14
        end

        st_nxt.irq = st_nxt.done && st_nxt.irq_en;                                // R1 R5 R19
    end

    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            st_r        <= '0;
            st_r.done   <= CONTROL_RESET[DONE_POS];                               // R18
            st_r.irq_en <= CONTROL_RESET[IRQ_ENABLE_POS];
            st_r.power  <= CONTROL_RESET[POWER_POS];
            st_r.state  <= ST_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign RDATA      = st_r.rdata;
    assign TRIAL_CODE = st_r.trial;
    assign POWER_ON   = st_r.power;
    assign BUSY       = st_r.busy;
    assign IRQ_REQ    = st_r.irq;
    assign WAKE       = st_r.irq;                                                 // R16
endmodule
`default_nettype wire

// [tb/analog_model.sv]
// analog front end: a held input level compared with the trial code
`timescale 1ns/10ps
`default_nettype none
module analog_model (
    input  wire logic [7:0] vin,   // held input, as a code
    input  wire logic [7:0] trial, // trial code from the ladder
    output logic            high   // input at or above the trial
);
    // input held constant for the whole conversion, no sample and hold
    assign high = (vin >= trial);
endmodule
`default_nettype wire

// [tb/sar_adc_control_props.sv]
// assertions on the converter control ports
`timescale 1ns/10ps
`default_nettype none
module sar_adc_control_props
    import adc_ctl_pkg::*;
(
    input wire logic       CLOCK,      // clock
    input wire logic       ARST_N,     // reset
    input wire logic [7:0] ADDR,       // address
    input wire logic [7:0] WDATA,      // write data
    input wire logic       WR,         // write
    input wire logic       RD,         // read
    input wire logic [7:0] RDATA,      // read data
    input wire logic       SYNC_OPT,   // sync option
    input wire logic [7:0] TRIAL_CODE, // trial
    input wire logic       POWER_ON,   // power
    input wire logic       BUSY,       // busy
    input wire logic       IRQ_REQ,    // request
    input wire logic       WAKE        // wake
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!ARST_N);
    wire ctl_wr = WR && (ADDR == CONTROL_ADDR);
    // sync starts excluded: their first step waits for the core
    wire go = ctl_wr && WDATA[5] && WDATA[4] && !SYNC_OPT;
    property p_wake; IRQ_REQ == WAKE; endproperty
    a_wake: assert property (p_wake) else $error("wake differs from request");
    property p_start; go |=> BUSY && (TRIAL_CODE == 8'h80); endproperty
    a_start: assert property (p_start) else $error("start not taken");
    property p_clear; ctl_wr && WDATA[5] |=> !IRQ_REQ; endproperty
    a_clear: assert property (p_clear) else $error("flag kept on start");
    property p_mask; ctl_wr && !WDATA[7] |=> !IRQ_REQ; endproperty
    a_mask: assert property (p_mask) else $error("masked request seen");
    property p_power; ctl_wr |=> POWER_ON == $past(WDATA[4]); endproperty
    a_power: assert property (p_power) else $error("power bit wrong");
    property p_rd; RD && ADDR == CONTROL_ADDR |=> RDATA[5:0] == {1'b0, $past(POWER_ON), 4'h0}; endproperty
    a_rd: assert property (p_rd) else $error("control read wrong");
    property p_idle; !RD |=> RDATA == 8'h00; endproperty
    a_idle: assert property (p_idle) else $error("read data outside read");
    property p_step; go |=> ##5 (TRIAL_CODE == 8'h80)[*8]; endproperty
    a_step: assert property (p_step) else $error("step came early");
    property p_msb; go |=> ##13 TRIAL_CODE[6:0] == 7'h40; endproperty
    a_msb: assert property (p_msb) else $error("second trial wrong");
endmodule
bind sar_adc_control sar_adc_control_props u_props (.CLOCK(CLOCK), .ARST_N(ARST_N),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .SYNC_OPT(SYNC_OPT),
    .TRIAL_CODE(TRIAL_CODE), .POWER_ON(POWER_ON), .BUSY(BUSY), .IRQ_REQ(IRQ_REQ), .WAKE(WAKE));
`default_nettype wire

// [tb/sar_adc_control_bench.sv]
// self-checking bench for the converter control block
`timescale 1ns/10ps
`default_nettype none
module sar_adc_control_bench;
    import adc_ctl_pkg::*;
    logic        clock = 1'b0;
    logic        arst_n = 1'b0;
    logic        wr = 1'b0, rd = 1'b0, sync_opt = 1'b0, core_wait = 1'b0;
    logic [7:0]  addr = 8'h00, wdata = 8'h00, vin = 8'h00;
    logic [7:0]  rdata, trial;
    logic        comp_high, power_on, busy, irq_req, wake;
    int          errors = 0, total_checks = 0, n;
    // write address, write data, read address, expected read
    logic [31:0] rows [4] = '{32'hd100_d140, 32'hd19f_d1d0, 32'h3c37_3c00, 32'hd012_d1d0};
    logic [7:0]  codes [4] = '{8'h00, 8'hff, 8'ha5, 8'h7f};
    sar_adc_control u_dut (.CLOCK(clock), .ARST_N(arst_n), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .SYNC_OPT(sync_opt), .CORE_WAIT(core_wait),
        .COMP_HIGH(comp_high), .TRIAL_CODE(trial), .POWER_ON(power_on), .BUSY(busy),
        .IRQ_REQ(irq_req), .WAKE(wake));
    analog_model u_analog (.vin(vin), .trial(trial), .high(comp_high));
    always #50 clock = ~clock;
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1 chk("read", exp, rdata);
    endtask
    // bounded: a hung converter must not stall the run
    task automatic wait_done;
        #1 n = 0;
        while (busy !== 1'b0 && n < 400) begin
            @(posedge clock);
            #1 n++;
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clock);
        arst_n <= 1'b1;
        rd_reg(CONTROL_ADDR, CONTROL_RESET);
        foreach (rows[i]) begin
            wr_reg(rows[i][31:24], rows[i][23:16]);
            rd_reg(rows[i][15:8], rows[i][7:0]);
        end
        chk("irq", 8'h03, {6'h00, wake, irq_req});
        foreach (codes[i]) begin
            vin <= codes[i];
            wr_reg(CONTROL_ADDR, 8'hb0);
            rd_reg(CONTROL_ADDR, 8'h90);
            wait_done;
            chk("steps", 8'(8 * CLK_DIV - 1), n[7:0]);
            chk("irq", 8'h03, {6'h00, wake, irq_req});
            rd_reg(RESULT_ADDR, codes[i]);
        end
        vin <= 8'h11;
        wr_reg(CONTROL_ADDR, 8'hb0);
        repeat (40) @(posedge clock);
        vin <= 8'he2;
        wr_reg(CONTROL_ADDR, 8'hb0);
        wait_done;
        chk("restart steps", 8'(8 * CLK_DIV + 1), n[7:0]);
        rd_reg(RESULT_ADDR, 8'he2);
        sync_opt <= 1'b1;
        vin <= 8'h3c;
        wr_reg(CONTROL_ADDR, 8'hb0);
        repeat (40) @(posedge clock);
        #1 chk("held", 8'h01, {7'h00, busy});
        core_wait <= 1'b1;
        wait_done;
        chk("wake", 8'h03, {6'h00, wake, irq_req});
        rd_reg(RESULT_ADDR, 8'h3c);
        core_wait <= 1'b0;
        sync_opt <= 1'b0;
        wr_reg(CONTROL_ADDR, 8'h10);
        #1 chk("masked", 8'h00, {6'h00, wake, irq_req});
        rd_reg(CONTROL_ADDR, 8'h50);
        wr_reg(CONTROL_ADDR, 8'hb0);
        repeat (20) @(posedge clock);
        arst_n <= 1'b0;
        @(posedge clock);
        #1 chk("abort", 8'h00, {6'h00, busy, irq_req});
        arst_n <= 1'b1;
        rd_reg(CONTROL_ADDR, CONTROL_RESET);
        wrap_up;
    end
    initial begin
        repeat (5000) @(posedge clock);
        errors++;
        wrap_up;
    end
endmodule
`default_nettype wire
